/* File: asm_sequencer.sv */
// mode sequencer: serial framing on the link clock, calibration and power state on clk
// assumes the track/hold result on sampleRaw is steady around the sampling instant
`timescale 1ns/1ps
`default_nettype none
module asm_sequencer
    import asm_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic serialClk,
    input wire logic chipSelN,
    input wire logic serialIn,
    output logic serialOut,
    input wire logic [RES_BITS-1:0] sampleRaw,
    input wire logic hardResetN,
    input wire logic power_down_n,
    output logic calBusy,
    output logic shutdownActive,
    output logic range_polarity_select,
    output logic internalClockSel,
    output logic user_output_zero,
    output logic user_output_one,
    output logic user_output_two
);

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: framing, acquisition and result shifting on serialClk

    typedef struct packed {
        asm_link_e state;
        logic [CYC_W-1:0] cyc;
        logic [CTRL_BITS-1:0] ctrl;
        logic rangeUni;
        logic modeUpper;
        logic isLong;
        logic prevLong;
        logic isShdn;
        logic [RES_BITS-1:0] word;
        logic dout;
        logic [3:0] tgl;
        logic [CFG_W-1:0] cfg;
    } asm_link_s;

    asm_link_s lr;
    asm_link_s next_lr;
    logic [RES_BITS-1:0] rawSync;
    logic [CYC_W-1:0] nextCyc;
    logic [CYC_W-1:0] period;
    logic [CYC_W-1:0] sampleAt;
    logic [CYC_W-1:0] outStart;
    logic [1:0] modeNow;
    logic [CTRL_BITS-1:0] byteNow;

    asm_sync_agree #(.W(RES_BITS), .RV('0)) u_rawSync (
        .clk(serialClk),
        .rst(rst),
        .en(1'b1),
        .d(sampleRaw),
        .q(rawSync)
    );

    always_comb begin
        nextCyc = lr.cyc + 6'h01;
        period = lr.isLong ? LONG_PERIOD : SHORT_PERIOD;
        sampleAt = (lr.isLong ? LONG_ACQ : SHORT_ACQ) + 6'h01;
        outStart = period - 6'(RES_BITS - 1);
        modeNow = {lr.modeUpper, serialIn};
        byteNow = {lr.ctrl[CTRL_BITS-2:0], serialIn};
    end

    always_comb begin
        next_lr = lr;
        if (chipSelN) begin
            // a raised select ends any frame; the next high bit starts afresh
            next_lr.state = L_IDLE;
            next_lr.cyc = '0;
            next_lr.dout = 1'b0;
        end else begin
            case (lr.state)
                L_IDLE: begin
                    next_lr.dout = 1'b0;
                    if (serialIn) begin
                        next_lr.state = L_CTRL;
                        next_lr.cyc = 6'h01;
                        next_lr.ctrl = {{(CTRL_BITS-1){1'b0}}, 1'b1};
                        next_lr.tgl[EV_START] = ~lr.tgl[EV_START];
                    end
                end
                L_CTRL: begin
                    next_lr.cyc = nextCyc;
                    next_lr.ctrl = byteNow;
                    if (nextCyc == CYC_RANGE) begin
                        next_lr.rangeUni = serialIn;
                    end
                    if (nextCyc == CYC_MODE_UPPER) begin
                        next_lr.modeUpper = serialIn;
                    end
                    if (nextCyc == CYC_MODE_LOWER) begin
                        case (modeNow)
                            MODE_SHORT: next_lr.isLong = 1'b0;
                            MODE_LONG: next_lr.isLong = 1'b1;
                            MODE_SWDOWN: next_lr.isLong = lr.prevLong;
                            default: next_lr.isLong = lr.prevLong;
                        endcase
                    end
                    if (nextCyc == CYC_BYTE_DONE) begin
                        next_lr.cfg = {byteNow[BIT_RANGE], byteNow[BIT_CLKSEL], byteNow[BIT_USER2:BIT_USER0]};
                        next_lr.tgl[EV_CFG] = ~lr.tgl[EV_CFG];
                        if ({lr.modeUpper, byteNow[3]} == MODE_CAL) begin
                            // calibration occupies no conversion frame on the link
                            next_lr.tgl[EV_CAL] = ~lr.tgl[EV_CAL];
                            next_lr.state = L_IDLE;
                        end else begin
                            next_lr.prevLong = lr.isLong;
                            next_lr.isShdn = ({lr.modeUpper, byteNow[3]} == MODE_SWDOWN);
                            next_lr.state = L_CONV;
                        end
                    end
                end
                L_CONV: begin
                    next_lr.cyc = nextCyc;
                    // the frame ends on the edge that shifts out the last result bit, so a host that
                    // deselects right after that bit still gets the shutdown it asked for
                    if (nextCyc == period) begin
                        next_lr.state = L_IDLE;
                        next_lr.dout = 1'b0;
                        if (lr.isShdn) begin
                            next_lr.tgl[EV_DOWN] = ~lr.tgl[EV_DOWN];
                        end
                    end
                end
                default: begin
                    next_lr.state = L_IDLE;
                end
            endcase
            // sampling instant; long mode samples after the byte is complete
            if (lr.state != L_IDLE && nextCyc == sampleAt) begin
                if (lr.rangeUni) begin
                    next_lr.word = rawSync;
                end else begin
                    next_lr.word = {~rawSync[RES_BITS-1], rawSync[RES_BITS-2:0]};
                end
            end
            // result shifts out over the last RES_BITS clocks of the period
            if (lr.state == L_CONV && nextCyc >= outStart && lr.cyc < period) begin
                next_lr.dout = lr.word[RES_BITS-1];
                next_lr.word = {lr.word[RES_BITS-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            lr <= '{state: L_IDLE, cyc: '0, ctrl: '0, rangeUni: RST_RANGE_UNI, modeUpper: 1'b0,
                    isLong: 1'b0, prevLong: 1'b0, isShdn: 1'b0, word: '0, dout: 1'b0,
                    tgl: '0, cfg: RST_CFG};
        end else begin
            lr <= next_lr;
        end
    end

    assign serialOut = lr.dout;

    ////////////////////////////////////////////////////////////////////////////////
    // core domain: calibration timer, power state and configuration outputs

    localparam int CAL_W = $clog2(CAL_LEN + 1);

    typedef struct packed {
        logic [3:0] tPrev;
        logic calRun;
        logic [CAL_W-1:0] calCnt;
        logic poweredDown;
        logic [CFG_W-1:0] cfg;
    } asm_core_s;

    asm_core_s cr;
    asm_core_s next_cr;
    logic [3:0] tglSync;
    logic [1:0] pinSync;
    logic [3:0] ev;

    asm_sync_agree #(.W(4), .RV(4'h0)) u_tglSync (
        .clk(clk),
        .rst(rst),
        .en(ce),
        .d(lr.tgl),
        .q(tglSync)
    );

    asm_sync_agree #(.W(2), .RV(RST_PINS)) u_pinSync (
        .clk(clk),
        .rst(rst),
        .en(ce),
        .d({hardResetN, power_down_n}),
        .q(pinSync)
    );

    always_comb begin
        ev = tglSync ^ cr.tPrev;
        next_cr = cr;
        if (ce) begin
            next_cr.tPrev = tglSync;
            // the link word is held since its toggle, so it is steady once the toggle lands
            if (ev[EV_CFG]) begin
                next_cr.cfg = lr.cfg;
            end
            if (ev[EV_START]) begin
                next_cr.calRun = 1'b0;
                next_cr.poweredDown = 1'b0;
            end
            if (cr.calRun) begin
                next_cr.calCnt = cr.calCnt + 1'b1;
                if (cr.calCnt == CAL_W'(CAL_LEN - 1)) begin
                    next_cr.calRun = 1'b0;
                end
            end
            if (ev[EV_CAL]) begin
                next_cr.calRun = 1'b1;
                next_cr.calCnt = '0;
            end
            if (ev[EV_DOWN]) begin
                next_cr.poweredDown = 1'b1;
            end
            if (!pinSync[0]) begin
                next_cr.poweredDown = 1'b1;
                next_cr.calRun = 1'b0;
            end
            if (!pinSync[1]) begin
                next_cr.calRun = 1'b0;
                next_cr.cfg = RST_CFG;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cr <= '{tPrev: 4'h0, calRun: 1'b0, calCnt: '0, poweredDown: 1'b0, cfg: RST_CFG};
        end else begin
            cr <= next_cr;
        end
    end

    // every status output is a core flip-flop, so it changes only on clk
    assign calBusy = cr.calRun;
    assign shutdownActive = cr.poweredDown;
    assign range_polarity_select = cr.cfg[CFG_RANGE];
    assign internalClockSel = cr.cfg[CFG_CLKSEL];
    assign user_output_two = cr.cfg[2];
    assign user_output_one = cr.cfg[1];
    assign user_output_zero = cr.cfg[0];

endmodule
`default_nettype wire

/* File: asm_pkg.sv */
// constants, field layout and types for the serial mode sequencer of a 14-bit sampling converter
// assumes a host that drives chip select, serial clock and serial data, and reads the result back
// Operation
// - mode bits 00 give a conversion with 5-cycle acquisition, 24-cycle period.
// - mode bits 11 give a conversion with 13-cycle acquisition, 32-cycle period.
// - mode bits upper 0, lower 1 start a self-calibration run.
// - calibration runs about 80,000 clock cycles unless aborted.
// - hard reset low, power-down low or a new start bit abort calibration.
// - mode bits upper 1, lower 0 convert, then enter low-power shutdown.
// - after software power-down, the next start bit wakes the device.
// - shutdown-mode conversion reuses the previous conversion's acquisition length.
// - shutdown follows the power-down pin low or the software shutdown code.
// - result is straight binary when unipolar, two's complement when bipolar.
// - chip select falling starts nothing; first high data bit is the start bit.
// - conversion begins after the eighth control bit has been clocked in.
// - result leaves most significant bit first in both ranges.
// - hard reset drives user outputs low, bipolar range, internal clock selected.
package asm_pkg;

    localparam int CTRL_BITS = 8;
    localparam int RES_BITS = 14;
    localparam int CYC_W = 6;
    localparam int CFG_W = 5;

    // control byte layout, first bit clocked in is the start bit
    localparam int BIT_RANGE = 6;
    localparam int BIT_CLKSEL = 5;
    localparam int BIT_USER2 = 2;
    localparam int BIT_USER0 = 0;

    // serial clock index (start bit = 1) at which each control field arrives
    localparam logic [CYC_W-1:0] CYC_RANGE = 6'h02;
    localparam logic [CYC_W-1:0] CYC_MODE_UPPER = 6'h04;
    localparam logic [CYC_W-1:0] CYC_MODE_LOWER = 6'h05;
    localparam logic [CYC_W-1:0] CYC_BYTE_DONE = 6'h08;

    localparam logic [1:0] MODE_SHORT = 2'h0;
    localparam logic [1:0] MODE_CAL = 2'h1;
    localparam logic [1:0] MODE_SWDOWN = 2'h2;
    localparam logic [1:0] MODE_LONG = 2'h3;

    localparam logic [CYC_W-1:0] SHORT_ACQ = 6'h05;
    localparam logic [CYC_W-1:0] SHORT_PERIOD = 6'h18;
    localparam logic [CYC_W-1:0] LONG_ACQ = 6'h0D;
    localparam logic [CYC_W-1:0] LONG_PERIOD = 6'h20;

    localparam int CAL_CYCLES = 80000;

    // config word order: range, clock select, user outputs two..zero
    localparam int CFG_RANGE = 4;
    localparam int CFG_CLKSEL = 3;
    localparam logic RST_RANGE_UNI = 1'b0;
    localparam logic RST_CLK_INT = 1'b1;
    localparam logic [2:0] RST_USER_OUT = 3'h0;
    localparam logic [CFG_W-1:0] RST_CFG = {RST_RANGE_UNI, RST_CLK_INT, RST_USER_OUT};

    localparam logic [1:0] RST_PINS = 2'h3;
    localparam int EV_START = 0;
    localparam int EV_CAL = 1;
    localparam int EV_DOWN = 2;
    localparam int EV_CFG = 3;

    typedef enum logic [1:0] {L_IDLE, L_CTRL, L_CONV} asm_link_e;

endpackage

/* File: asm_sync_agree.sv */
// three-stage synchroniser; the output takes a new value only once stages two and three agree
// assumes the input changes slowly against clk, or is held stable by a handshake
`timescale 1ns/1ps
`default_nettype none
module asm_sync_agree #(
    parameter int W = 1,
    parameter logic [W-1:0] RV = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } asm_sync_s;

    asm_sync_s r;
    asm_sync_s next_r;

    always_comb begin
        next_r = r;
        if (en) begin
            next_r.s1 = d;
            next_r.s2 = r.s1;
            next_r.s3 = r.s2;
            if (r.s2 == r.s3) begin
                next_r.q = r.s3;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= {RV, RV, RV, RV};
        end else begin
            r <= next_r;
        end
    end

    assign q = r.q;
endmodule
`default_nettype wire

/* File: asm_host_model.sv */
// host serial controller: frames a control byte and clocks the result back
// assumes one caller at a time; the link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module asm_host_model
    import asm_pkg::*;
(
    output logic serialClk,
    output logic chipSelN,
    output logic serialIn,
    input wire logic serialOut
);
    initial begin
        serialClk = 1'b0;
        chipSelN = 1'b1;
        serialIn = 1'b0;
    end
    // pre idle zeros, then n clocks; the last RES_BITS bits are taken on falling edges
    task automatic frame(input int pre, input logic [7:0] ctl, input int n, output logic [RES_BITS-1:0] res);
        int k;
        res = '0;
        #3 chipSelN = 1'b0;
        for (k = 1 - pre; k <= n; k++) begin
            serialIn = (k >= 1 && k <= CTRL_BITS) ? ctl[CTRL_BITS-k] : 1'b0;
            #7.5 serialClk = 1'b1;
            #7.5 serialClk = 1'b0;
            if (k > n - RES_BITS) begin
                res = {res[RES_BITS-2:0], serialOut};
            end
        end
        // pulse select high over one edge so the next start bit is a fresh frame
        chipSelN = 1'b1;
        serialIn = 1'b1;
        #7.5 serialClk = 1'b1;
        #7.5 serialClk = 1'b0;
        serialIn = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: asm_sequencer_chk.sv */
// timing checks on the sequencer's ports, both clock domains
// assumes ce held high whenever calibration length is judged
`timescale 1ns/1ps
`default_nettype none
module asm_sequencer_chk
    import asm_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic serialClk,
    input wire logic chipSelN,
    input wire logic serialOut,
    input wire logic hardResetN,
    input wire logic power_down_n,
    input wire logic calBusy,
    input wire logic shutdownActive,
    input wire logic range_polarity_select,
    input wire logic internalClockSel,
    input wire logic user_output_zero,
    input wire logic user_output_one,
    input wire logic user_output_two
);
    logic [31:0] calRun;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            calRun <= '0;
        end else if (ce) begin
            calRun <= calBusy ? calRun + 32'h1 : 32'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_out_idle_cs: assert property (@(posedge serialClk) disable iff (rst)
        $past(chipSelN) |-> !serialOut) else $error("result bit while deselected");
    a_out_late: assert property (@(posedge serialClk) disable iff (rst)
        $rose(serialOut) |-> !$past(chipSelN, 8)) else $error("result bit too early in frame");
    a_cal_pin: assert property (@(posedge clk) disable iff (rst)
        (!power_down_n && calBusy) |-> ##[1:8] !calBusy) else $error("calibration kept on pin shutdown");
    a_cal_hrst: assert property (@(posedge clk) disable iff (rst)
        (!hardResetN && calBusy) |-> ##[1:8] !calBusy) else $error("calibration kept on hard reset");
    a_down_pin: assert property (@(posedge clk) disable iff (rst)
        !power_down_n [*6] |=> shutdownActive) else $error("no shutdown on pin low");
    a_down_hold: assert property (@(posedge clk) disable iff (rst)
        (shutdownActive && !power_down_n) |=> shutdownActive) else $error("woke with pin low");
    a_rst_cfg: assert property (@(posedge clk) disable iff (rst)
        !hardResetN [*6] |-> !range_polarity_select && internalClockSel && !user_output_zero
        && !user_output_one && !user_output_two) else $error("defaults not restored");
    // slack of two covers the edge counting of rise and fall
    a_cal_len: assert property (@(posedge clk) disable iff (rst)
        calRun <= CAL_LEN + 2) else $error("calibration overran");
endmodule
bind asm_sequencer asm_sequencer_chk #(.CAL_LEN(CAL_LEN)) i_asm_sequencer_chk (.clk(clk), .rst(rst), .ce(ce),
    .serialClk(serialClk), .chipSelN(chipSelN), .serialOut(serialOut), .hardResetN(hardResetN),
    .power_down_n(power_down_n), .calBusy(calBusy), .shutdownActive(shutdownActive),
    .range_polarity_select(range_polarity_select), .internalClockSel(internalClockSel),
    .user_output_zero(user_output_zero), .user_output_one(user_output_one), .user_output_two(user_output_two));
`default_nettype wire

/* File: asm_sequencer_bench.sv */
// self-checking bench: conversions in every mode, calibration and its aborts
// assumes the host model owns the link pins; a short calibration length
`timescale 1ns/1ps
`default_nettype none
module asm_sequencer_bench
    import asm_pkg::*;
;
    localparam int CAL_N = 50;
    logic clk, rst, ce, serialClk, chipSelN, serialIn, serialOut, hardResetN, power_down_n;
    logic calBusy, shutdownActive, range_polarity_select, internalClockSel;
    logic user_output_zero, user_output_one, user_output_two;
    logic [RES_BITS-1:0] sampleRaw, res;
    logic [4:0] cfg;
    logic busyNow, downNow;
    int failures = 0;
    int n_tests = 0;
    // outputs are copied on the falling edge so checks never race the clk edge that launches them
    always @(negedge clk) begin
        cfg <= {range_polarity_select, internalClockSel, user_output_two, user_output_one, user_output_zero};
        busyNow <= calBusy;
        downNow <= shutdownActive;
    end
    asm_sequencer #(.CAL_LEN(CAL_N)) i_asm_sequencer (.clk(clk), .rst(rst), .ce(ce), .serialClk(serialClk),
        .chipSelN(chipSelN), .serialIn(serialIn), .serialOut(serialOut), .sampleRaw(sampleRaw),
        .hardResetN(hardResetN), .power_down_n(power_down_n), .calBusy(calBusy),
        .shutdownActive(shutdownActive), .range_polarity_select(range_polarity_select),
        .internalClockSel(internalClockSel), .user_output_zero(user_output_zero),
        .user_output_one(user_output_one), .user_output_two(user_output_two));
    asm_host_model i_asm_host_model (.serialClk(serialClk), .chipSelN(chipSelN), .serialIn(serialIn),
        .serialOut(serialOut));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // raw code is set well ahead of the sampling instant
    task automatic conv(input int pre, input logic [7:0] ctl, input int n, input logic [13:0] raw, exp);
        tick(1);
        sampleRaw <= raw;
        tick(1);
        i_asm_host_model.frame(pre, ctl, n, res);
        check("result", 16'(res), 16'(exp));
        tick(10);
    endtask
    task automatic cal(input logic [7:0] ctl);
        i_asm_host_model.frame(0, ctl, CTRL_BITS, res);
        tick(10);
        check("calBusy", 16'(busyNow), 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (25000) @(posedge clk);
        failures++;
        end_sim();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        hardResetN = 1'b1;
        power_down_n = 1'b1;
        sampleRaw = '0;
        tick(8);
        rst <= 1'b0;
        tick(6);
        check("cfg", 16'(cfg), 16'h0008);
        check("flags", 16'({busyNow, downNow}), 16'h0000);
        conv(0, 8'hE5, 24, 14'h2A5C, 14'h2A5C);
        check("cfg", 16'(cfg), 16'h001D);
        conv(3, 8'hA2, 24, 14'h1234, 14'h3234);
        check("cfg", 16'(cfg), 16'h000A);
        conv(0, 8'hD8, 32, 14'h3FFE, 14'h3FFE);
        conv(0, 8'hD0, 32, 14'h0001, 14'h0001);
        check("shutdown", 16'(downNow), 16'h0001);
        conv(0, 8'hC0, 24, 14'h0F0F, 14'h0F0F);
        check("shutdown", 16'(downNow), 16'h0000);
        // calibrate with the external clock that the conversions below use
        cal(8'hC8);
        check("cfg", 16'(cfg), 16'h0010);
        tick(CAL_N - 15);
        check("calBusy", 16'(busyNow), 16'h0001);
        tick(20);
        check("calBusy", 16'(busyNow), 16'h0000);
        cal(8'hC8);
        power_down_n <= 1'b0;
        tick(10);
        check("calBusy", 16'(busyNow), 16'h0000);
        check("shutdown", 16'(downNow), 16'h0001);
        power_down_n <= 1'b1;
        cal(8'hC8);
        conv(0, 8'hC0, 24, 14'h00FF, 14'h00FF);
        check("flags", 16'({busyNow, downNow}), 16'h0000);
        cal(8'hEF);
        check("cfg", 16'(cfg), 16'h001F);
        // a low enable freezes the calibration count past its natural end
        ce <= 1'b0;
        tick(60);
        check("calBusy", 16'(busyNow), 16'h0001);
        ce <= 1'b1;
        hardResetN <= 1'b0;
        tick(10);
        check("calBusy", 16'(busyNow), 16'h0000);
        check("cfg", 16'(cfg), 16'h0008);
        hardResetN <= 1'b1;
        tick(4);
        end_sim();
    end
endmodule
`default_nettype wire
